// ===== verilog/ldc_defs.svh
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH

// Register addresses
`define LDC_ADDR_CURR_LIMIT   8'h05
`define LDC_ADDR_DRV_CTRL     8'h06
`define LDC_ADDR_LINE_CFG     8'h07
`define LDC_REG_RESET         8'h00
// current_limit_config fields
`define LDC_LIMIT_LEVEL_HI    7
`define LDC_LIMIT_LEVEL_LO    6
`define LDC_LIMIT_DISABLE     5
`define LDC_BLANK_HI          4
`define LDC_BLANK_LO          3
`define LDC_RETRY_HI          2
`define LDC_RETRY_LO          1
`define LDC_AUTO_RETRY_ON     0
// driver_receiver_control fields
`define LDC_LOW_RAIL_REG_OFF  7
`define LDC_WAKE_DET_DISABLE  6
`define LDC_AUX_RX_DISABLE    5
`define LDC_AUX_GLITCH_FILT   4
`define LDC_RX_OUT_DISABLE    3
`define LDC_LINE_GLITCH_FILT  2
`define LDC_AUX_SOFT_LEVEL    1
`define LDC_LINE_SOFT_LEVEL   0
// line_driver_config fields
`define LDC_SLEW_HI           7
`define LDC_SLEW_LO           6
`define LDC_LINE_PULLDOWN     5
`define LDC_LINE_PULLUP       4
`define LDC_LINE_LOW_SIDE     3
`define LDC_LINE_PUSH_PULL    2
`define LDC_LINE_POLARITY     1
`define LDC_LINE_DRV_ENABLE   0
// Timing
`define LDC_CLK_MHZ           10
`define LDC_BLANK_T0_US       128
`define LDC_BLANK_T1_US       500
`define LDC_BLANK_T2_MS       1
`define LDC_BLANK_T3_MS       5
`define LDC_RETRY_T0_MS       50
`define LDC_RETRY_T1_MS       100
`define LDC_RETRY_T2_MS       200
`define LDC_RETRY_T3_MS       500
`define LDC_GLITCH_US         1
`define LDC_GLITCH_CYC        (`LDC_GLITCH_US * `LDC_CLK_MHZ)
`define LDC_CNT_W             23
`endif

// ===== verilog/ldc_pkg.sv
package ldc_pkg;
   // Per-driver fault guard phases
   typedef enum logic [1:0] {
      G_IDLE,
      G_BLANK,
      G_RETRY,
      G_LATCHED
   } ldc_guard_st_t;

   typedef struct packed {
      ldc_guard_st_t st;
      logic [22:0]   cnt;
      logic          off;
   } ldc_guard_state_t;

   typedef struct packed {
      logic [3:0] cnt;
      logic       out;
   } ldc_filt_state_t;

   typedef struct packed {
      logic [7:0] cl_cfg;
      logic [7:0] ctl;
      logic [7:0] lcfg;
      logic [7:0] rdata;
      logic [1:0] lim_lvl;
      logic       lim_on;
      logic       rail_on;
      logic       wake_en;
      logic [1:0] slew;
      logic       pd;
      logic       pu;
      logic       hs_on;
      logic       ls_on;
      logic       aux_act;
      logic       aux_lvl;
      logic       rx;
      logic       rx_oe;
      logic       aux_pin;
      logic       aux_pin_oe;
      logic       line_stat;
      logic       aux_stat;
      logic       line_flt;
      logic       aux_flt;
   } ldc_top_state_t;
endpackage

// ===== verilog/ldc_glitch_filter.sv
`include "ldc_defs.svh"
// Passes a level only after it has held steady for GLITCH_CYC cycles
module ldc_glitch_filter (
   input  wire logic CLK_I,
   input  wire logic SRST_I,
   input  wire logic raw_i,
   input  wire logic filt_en_i,
   output logic      out_o
);
   import ldc_pkg::*;
   localparam logic [3:0] GLITCH_CYC = 4'(`LDC_GLITCH_CYC);

   ldc_filt_state_t q_ff;
   ldc_filt_state_t nxt_q;

   // Bypass follows raw at once; filter restarts its count on every bounce
   always_comb begin
      nxt_q = q_ff;
      if (!filt_en_i || raw_i == q_ff.out) begin
         nxt_q.cnt = 4'h0;
         nxt_q.out = raw_i;
      end else if (q_ff.cnt == GLITCH_CYC - 4'h1) begin
         nxt_q.cnt = 4'h0;
         nxt_q.out = raw_i;
      end else begin
         nxt_q.cnt = q_ff.cnt + 4'h1;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) q_ff <= '0;
      else        q_ff <= nxt_q;
   end

   assign out_o = q_ff.out;
endmodule // ldc_glitch_filter

// ===== verilog/ldc_fault_guard.sv
// Overcurrent blanking, timed retry and latched shutdown for one driver
module ldc_fault_guard (
   input  wire logic        CLK_I,
   input  wire logic        SRST_I,
   input  wire logic        overcur_i,
   input  wire logic        arm_i,
   input  wire logic [22:0] blank_cyc_i,
   input  wire logic [22:0] retry_cyc_i,
   input  wire logic        auto_retry_i,
   input  wire logic        clear_i,
   output logic            off_o
);
   import ldc_pkg::*;

   ldc_guard_state_t q_ff;
   ldc_guard_state_t nxt_q;

   // A fault counts only once overcurrent outlasts the blanking time
   always_comb begin
      nxt_q = q_ff;
      case (q_ff.st)
         G_IDLE: begin
            nxt_q.cnt = '0;
            nxt_q.off = 1'b0;
            if (overcur_i && arm_i) nxt_q.st = G_BLANK;
         end
         G_BLANK: begin
            if (!overcur_i || !arm_i) begin
               nxt_q.st = G_IDLE;
            end else if (q_ff.cnt >= blank_cyc_i - 23'h1) begin
               nxt_q.cnt = '0;
               nxt_q.off = 1'b1;
               nxt_q.st  = auto_retry_i ? G_RETRY : G_LATCHED;
            end else begin
               nxt_q.cnt = q_ff.cnt + 23'h1;
            end
         end
         G_RETRY: begin
            if (q_ff.cnt >= retry_cyc_i - 23'h1) begin
               nxt_q.st = G_IDLE;
            end else begin
               nxt_q.cnt = q_ff.cnt + 23'h1;
            end
         end
         G_LATCHED: begin
            if (clear_i) nxt_q.st = G_IDLE;
         end
         default: nxt_q.st = G_IDLE;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (SRST_I) q_ff <= '{st: G_IDLE, cnt: '0, off: 1'b0};
      else        q_ff <= nxt_q;
   end

   assign off_o = q_ff.off;
endmodule // ldc_fault_guard

// ===== verilog/ldc_line_driver_ctrl.sv
`include "ldc_defs.svh"
// Register bank and pin logic for the line driver and auxiliary driver
module ldc_line_driver_ctrl #(
   parameter int unsigned BLANK_500US_CYC = `LDC_BLANK_T1_US * `LDC_CLK_MHZ,
   parameter int unsigned BLANK_1MS_CYC   = `LDC_BLANK_T2_MS * 1000 * `LDC_CLK_MHZ,
   parameter int unsigned BLANK_5MS_CYC   = `LDC_BLANK_T3_MS * 1000 * `LDC_CLK_MHZ,
   parameter int unsigned RETRY_50MS_CYC  = `LDC_RETRY_T0_MS * 1000 * `LDC_CLK_MHZ,
   parameter int unsigned RETRY_100MS_CYC = `LDC_RETRY_T1_MS * 1000 * `LDC_CLK_MHZ,
   parameter int unsigned RETRY_200MS_CYC = `LDC_RETRY_T2_MS * 1000 * `LDC_CLK_MHZ,
   parameter int unsigned RETRY_500MS_CYC = `LDC_RETRY_T3_MS * 1000 * `LDC_CLK_MHZ
) (
   input  wire logic       CLK_I,
   input  wire logic       SRST_I,
   // Register port
   input  wire logic [7:0] REG_ADDR_I,
   input  wire logic [7:0] REG_WDATA_I,
   input  wire logic       REG_WR_I,
   input  wire logic       REG_RD_I,
   output logic      [7:0] REG_RDATA_O,
   // Line and aux inputs
   input  wire logic       TX_I,
   input  wire logic       TXEN_I,
   input  wire logic       LINE_SENSE_I,
   input  wire logic       AUX_SENSE_I,
   input  wire logic       LINE_OVERCUR_I,
   input  wire logic       AUX_OVERCUR_I,
   input  wire logic       AUX_DRV_EN_I,
   input  wire logic       REGISTER_CORRUPTION_FLAG_I,
   // Shared limit and supply controls
   output logic      [1:0] LIMIT_LEVEL_O,
   output logic            LIMIT_ACTIVE_O,
   output logic            LOW_RAIL_REG_ON_O,
   output logic            WAKE_DETECT_EN_O,
   // Line driver
   output logic      [1:0] LINE_SLEW_SELECT_O,
   output logic            LINE_WEAK_PULLDOWN_O,
   output logic            LINE_WEAK_PULLUP_O,
   output logic            LINE_HIGH_SIDE_ON_O,
   output logic            LINE_LOW_SIDE_ON_O,
   output logic            LINE_FAULT_O,
   // Aux driver
   output logic            AUX_DRV_ACTIVE_O,
   output logic            AUX_DRV_LEVEL_O,
   output logic            AUX_FAULT_O,
   // Logic side outputs and level status
   output logic            RX_O,
   output logic            RX_OE_O,
   output logic            AUX_LOGIC_PIN_O,
   output logic            AUX_LOGIC_PIN_OE_O,
   output logic            LINE_LEVEL_STATUS_O,
   output logic            AUX_LEVEL_STATUS_O
);
   import ldc_pkg::*;

   localparam int unsigned BLANK_128US_CYC = `LDC_BLANK_T0_US * `LDC_CLK_MHZ;

   ldc_top_state_t q_ff;
   ldc_top_state_t nxt_q;

   logic [22:0] blank_cyc;
   logic [22:0] retry_cyc;
   logic        line_off;
   logic        aux_off;
   logic        line_filt;
   logic        aux_filt;
   logic        limit_wr;
   logic        corrupt;

   assign corrupt  = REGISTER_CORRUPTION_FLAG_I;
   // Writing the limit register is the host's way to release a latched driver
   assign limit_wr = REG_WR_I && (REG_ADDR_I == `LDC_ADDR_CURR_LIMIT);

   // Blanking interval lookup
   always_comb begin
      case (q_ff.cl_cfg[`LDC_BLANK_HI:`LDC_BLANK_LO])
         2'h0:    blank_cyc = 23'(BLANK_128US_CYC);
         2'h1:    blank_cyc = 23'(BLANK_500US_CYC);
         2'h2:    blank_cyc = 23'(BLANK_1MS_CYC);
         default: blank_cyc = 23'(BLANK_5MS_CYC);
      endcase
   end

   // Retry off-time lookup
   always_comb begin
      case (q_ff.cl_cfg[`LDC_RETRY_HI:`LDC_RETRY_LO])
         2'h0:    retry_cyc = 23'(RETRY_50MS_CYC);
         2'h1:    retry_cyc = 23'(RETRY_100MS_CYC);
         2'h2:    retry_cyc = 23'(RETRY_200MS_CYC);
         default: retry_cyc = 23'(RETRY_500MS_CYC);
      endcase
   end

   // Fault guard for the line driver; armed only while it actually drives
   ldc_fault_guard u_line_guard (
      .CLK_I        (CLK_I),
      .SRST_I       (SRST_I),
      .overcur_i    (LINE_OVERCUR_I),
      .arm_i        (q_ff.hs_on | q_ff.ls_on),
      .blank_cyc_i  (blank_cyc),
      .retry_cyc_i  (retry_cyc),
      .auto_retry_i (q_ff.cl_cfg[`LDC_AUTO_RETRY_ON]),
      .clear_i      (limit_wr),
      .off_o        (line_off)
   );

   // Fault guard for the aux driver
   ldc_fault_guard u_aux_guard (
      .CLK_I        (CLK_I),
      .SRST_I       (SRST_I),
      .overcur_i    (AUX_OVERCUR_I),
      .arm_i        (q_ff.aux_act),
      .blank_cyc_i  (blank_cyc),
      .retry_cyc_i  (retry_cyc),
      .auto_retry_i (q_ff.cl_cfg[`LDC_AUTO_RETRY_ON]),
      .clear_i      (limit_wr),
      .off_o        (aux_off)
   );

   // Line receiver glitch filter
   ldc_glitch_filter u_line_filt (
      .CLK_I     (CLK_I),
      .SRST_I    (SRST_I),
      .raw_i     (LINE_SENSE_I),
      .filt_en_i (q_ff.ctl[`LDC_LINE_GLITCH_FILT]),
      .out_o     (line_filt)
   );

   // Aux receiver glitch filter
   ldc_glitch_filter u_aux_filt (
      .CLK_I     (CLK_I),
      .SRST_I    (SRST_I),
      .raw_i     (AUX_SENSE_I),
      .filt_en_i (q_ff.ctl[`LDC_AUX_GLITCH_FILT]),
      .out_o     (aux_filt)
   );

   // Next state: register writes, readback and every pin output
   always_comb begin
      logic line_data;
      logic pin_lvl;
      logic line_act;
      line_data = 1'b0;
      pin_lvl   = 1'b0;
      line_act  = 1'b0;
      nxt_q     = q_ff;

      // Register writes; unmapped addresses are ignored
      if (REG_WR_I) begin
         if (REG_ADDR_I == `LDC_ADDR_CURR_LIMIT) begin
            nxt_q.cl_cfg = REG_WDATA_I;
         end else if (REG_ADDR_I == `LDC_ADDR_DRV_CTRL) begin
            nxt_q.ctl = REG_WDATA_I;
         end else if (REG_ADDR_I == `LDC_ADDR_LINE_CFG) begin
            nxt_q.lcfg = REG_WDATA_I;
         end
      end

      // Readback; the word holds until the next read strobe
      if (REG_RD_I) begin
         if (REG_ADDR_I == `LDC_ADDR_CURR_LIMIT) begin
            nxt_q.rdata = q_ff.cl_cfg;
         end else if (REG_ADDR_I == `LDC_ADDR_DRV_CTRL) begin
            nxt_q.rdata = q_ff.ctl;
         end else if (REG_ADDR_I == `LDC_ADDR_LINE_CFG) begin
            nxt_q.rdata = q_ff.lcfg;
         end else begin
            nxt_q.rdata = 8'h00;
         end
      end

      // Shared current limit level and enable
      nxt_q.lim_lvl = q_ff.cl_cfg[`LDC_LIMIT_LEVEL_HI:`LDC_LIMIT_LEVEL_LO];
      nxt_q.lim_on  = ~q_ff.cl_cfg[`LDC_LIMIT_DISABLE];

      // Corruption forces the low rail on so the host keeps its supply
      nxt_q.rail_on = ~q_ff.ctl[`LDC_LOW_RAIL_REG_OFF] | corrupt;
      nxt_q.wake_en = ~q_ff.ctl[`LDC_WAKE_DET_DISABLE];

      // Static line driver shaping
      nxt_q.slew = q_ff.lcfg[`LDC_SLEW_HI:`LDC_SLEW_LO];
      nxt_q.pd   = q_ff.lcfg[`LDC_LINE_PULLDOWN];
      nxt_q.pu   = q_ff.lcfg[`LDC_LINE_PULLUP];

      // Line driver: transmit or soft level, then polarity, then output stage
      line_data = TX_I | q_ff.ctl[`LDC_LINE_SOFT_LEVEL];
      pin_lvl   = q_ff.lcfg[`LDC_LINE_POLARITY] ? line_data : ~line_data;
      line_act  = q_ff.lcfg[`LDC_LINE_DRV_ENABLE] & TXEN_I
                  & ~line_off & ~corrupt;
      if (!line_act) begin
         nxt_q.hs_on = 1'b0;
         nxt_q.ls_on = 1'b0;
      end else if (q_ff.lcfg[`LDC_LINE_PUSH_PULL]) begin
         nxt_q.hs_on = pin_lvl;
         nxt_q.ls_on = ~pin_lvl;
      end else if (q_ff.lcfg[`LDC_LINE_LOW_SIDE]) begin
         nxt_q.hs_on = 1'b0;
         nxt_q.ls_on = ~pin_lvl;
      end else begin
         nxt_q.hs_on = pin_lvl;
         nxt_q.ls_on = 1'b0;
      end
      nxt_q.line_flt = line_off;

      // Aux driver follows its soft level bit
      nxt_q.aux_act = AUX_DRV_EN_I & ~aux_off & ~corrupt;
      nxt_q.aux_lvl = q_ff.ctl[`LDC_AUX_SOFT_LEVEL];
      nxt_q.aux_flt = aux_off;

      // Receive path; status reads one when the filtered line is low and the receive output disable bit is clear, even under corruption
      nxt_q.rx    = q_ff.lcfg[`LDC_LINE_POLARITY] ? line_filt : ~line_filt;
      nxt_q.rx_oe = ~q_ff.ctl[`LDC_RX_OUT_DISABLE] & ~corrupt;
      nxt_q.line_stat = ~line_filt & ~q_ff.ctl[`LDC_RX_OUT_DISABLE];

      // Aux logic pin is an output only while the aux driver is idle
      if (q_ff.ctl[`LDC_AUX_RX_DISABLE]) begin
         nxt_q.aux_pin  = 1'b0;
         nxt_q.aux_stat = 1'b0;
      end else begin
         nxt_q.aux_pin  = aux_filt;
         nxt_q.aux_stat = ~aux_filt;
      end
      nxt_q.aux_pin_oe = ~AUX_DRV_EN_I & ~corrupt;
   end

   // Single state register; everything resets to zero
   always_ff @(posedge CLK_I) begin
      if (SRST_I) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // Outputs straight from the state register
   assign REG_RDATA_O          = q_ff.rdata;
   assign LIMIT_LEVEL_O        = q_ff.lim_lvl;
   assign LIMIT_ACTIVE_O       = q_ff.lim_on;
   assign LOW_RAIL_REG_ON_O    = q_ff.rail_on;
   assign WAKE_DETECT_EN_O     = q_ff.wake_en;
   assign LINE_SLEW_SELECT_O   = q_ff.slew;
   assign LINE_WEAK_PULLDOWN_O = q_ff.pd;
   assign LINE_WEAK_PULLUP_O   = q_ff.pu;
   assign LINE_HIGH_SIDE_ON_O  = q_ff.hs_on;
   assign LINE_LOW_SIDE_ON_O   = q_ff.ls_on;
   assign LINE_FAULT_O         = q_ff.line_flt;
   assign AUX_DRV_ACTIVE_O     = q_ff.aux_act;
   assign AUX_DRV_LEVEL_O      = q_ff.aux_lvl;
   assign AUX_FAULT_O          = q_ff.aux_flt;
   assign RX_O                 = q_ff.rx;
   assign RX_OE_O              = q_ff.rx_oe;
   assign AUX_LOGIC_PIN_O      = q_ff.aux_pin;
   assign AUX_LOGIC_PIN_OE_O   = q_ff.aux_pin_oe;
   assign LINE_LEVEL_STATUS_O  = q_ff.line_stat;
   assign AUX_LEVEL_STATUS_O   = q_ff.aux_stat;
endmodule // ldc_line_driver_ctrl

// ===== testbench/ldc_host_model.sv
// Host side of the register port: one strobe per access, bus turned over when idle
module ldc_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic      [7:0] addr_o,
   output logic      [7:0] wdata_o,
   output logic            wr_o,
   output logic            rd_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // Write: strobe and data held through the taking edge, then dropped
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge clk_i);
      #1;
      wr_o = 1'b0;
      addr_o = ~a; // Released bus never shows the last value
      wdata_o = ~d;
   endtask

   // Read: answer is registered, so it is in place once the taking edge has passed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr_o = a;
      rd_o = 1'b1;
      @(posedge clk_i);
      #1;
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
   endtask
endmodule // ldc_host_model

// ===== testbench/ldc_line_driver_ctrl_sva.sv
module ldc_line_driver_ctrl_sva (
   input wire logic       CLK_I,
   input wire logic       SRST_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic       REG_WR_I,
   input wire logic       REG_RD_I,
   input wire logic [7:0] REG_RDATA_O,
   input wire logic       REGISTER_CORRUPTION_FLAG_I,
   input wire logic [1:0] LIMIT_LEVEL_O,
   input wire logic       LIMIT_ACTIVE_O,
   input wire logic       LOW_RAIL_REG_ON_O,
   input wire logic       WAKE_DETECT_EN_O,
   input wire logic [1:0] LINE_SLEW_SELECT_O,
   input wire logic       LINE_WEAK_PULLDOWN_O,
   input wire logic       LINE_WEAK_PULLUP_O,
   input wire logic       LINE_HIGH_SIDE_ON_O,
   input wire logic       LINE_LOW_SIDE_ON_O,
   input wire logic       LINE_FAULT_O,
   input wire logic       AUX_DRV_ACTIVE_O,
   input wire logic       AUX_DRV_LEVEL_O,
   input wire logic       RX_OE_O,
   input wire logic       AUX_LOGIC_PIN_O,
   input wire logic       AUX_LOGIC_PIN_OE_O,
   input wire logic       LINE_LEVEL_STATUS_O,
   input wire logic       AUX_LEVEL_STATUS_O
);
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0] cl;
      logic [7:0] ct;
      logic [7:0] lc;
      logic       wcl;
      logic       wcl2;
   } ldc_shadow_t;
   ldc_shadow_t sh_ff;
   ldc_shadow_t nxt_sh;
   logic        wr_cl;
   logic [7:0]  rd_exp;

   // Shadow of the bank; two-cycle history of limit writes covers the release latency
   assign wr_cl = REG_WR_I && REG_ADDR_I == 8'h05;
   always_comb begin
      nxt_sh = sh_ff;
      nxt_sh.wcl = wr_cl;
      nxt_sh.wcl2 = sh_ff.wcl;
      if (wr_cl) nxt_sh.cl = REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == 8'h06) nxt_sh.ct = REG_WDATA_I;
      if (REG_WR_I && REG_ADDR_I == 8'h07) nxt_sh.lc = REG_WDATA_I;
      if (SRST_I) nxt_sh = '0;
   end
   always_ff @(posedge CLK_I) sh_ff <= nxt_sh;

   // Unmapped places read as zero
   always_comb begin
      case (REG_ADDR_I)
         8'h05:   rd_exp = sh_ff.cl;
         8'h06:   rd_exp = sh_ff.ct;
         8'h07:   rd_exp = sh_ff.lc;
         default: rd_exp = 8'h00;
      endcase
   end

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SRST_I);

   read_data_a: assert property (REG_RD_I |=> REG_RDATA_O == $past(rd_exp))
      else $error("read data wrong");
   lim_level_a: assert property (!$past(SRST_I) |-> LIMIT_LEVEL_O == $past(sh_ff.cl[7:6]))
      else $error("limit level wrong");
   lim_active_a: assert property (!$past(SRST_I) |-> LIMIT_ACTIVE_O == !$past(sh_ff.cl[5]))
      else $error("limit enable wrong");
   rail_reg_a: assert property (!$past(SRST_I) |-> LOW_RAIL_REG_ON_O ==
      (!$past(sh_ff.ct[7]) || $past(REGISTER_CORRUPTION_FLAG_I))) else $error("rail wrong");
   wake_det_a: assert property (!$past(SRST_I) |-> WAKE_DETECT_EN_O == !$past(sh_ff.ct[6]))
      else $error("wake detect wrong");
   line_shape_a: assert property (!$past(SRST_I) |-> {LINE_SLEW_SELECT_O,
      LINE_WEAK_PULLDOWN_O, LINE_WEAK_PULLUP_O} == $past(sh_ff.lc[7:4])) else $error("slew");
   aux_level_a: assert property (!$past(SRST_I) |-> AUX_DRV_LEVEL_O == $past(sh_ff.ct[1]))
      else $error("aux level wrong");
   rx_float_a: assert property ($past(sh_ff.ct[3]) |-> !RX_OE_O && !LINE_LEVEL_STATUS_O)
      else $error("receive output not floated");
   aux_off_a: assert property ($past(sh_ff.ct[5]) |-> !AUX_LEVEL_STATUS_O && !AUX_LOGIC_PIN_O)
      else $error("aux receiver not off");
   line_off_a: assert property (!$past(sh_ff.lc[0]) |-> !LINE_HIGH_SIDE_ON_O &&
      !LINE_LOW_SIDE_ON_O) else $error("disabled line driver on");
   corrupt_off_a: assert property ($past(REGISTER_CORRUPTION_FLAG_I) |->
      !LINE_HIGH_SIDE_ON_O && !LINE_LOW_SIDE_ON_O && !AUX_DRV_ACTIVE_O && !RX_OE_O &&
      !AUX_LOGIC_PIN_OE_O) else $error("outputs live while corrupt");
   latch_hold_a: assert property (LINE_FAULT_O && !sh_ff.cl[0] && !wr_cl && !sh_ff.wcl &&
      !sh_ff.wcl2 |=> LINE_FAULT_O) else $error("latched fault released");

   line_cfg_cov: cover property (REG_WR_I && REG_ADDR_I == 8'h07);
   fault_rise_cov: cover property ($rose(LINE_FAULT_O));
   retry_end_cov: cover property ($fell(LINE_FAULT_O) && sh_ff.cl[0]);
endmodule // ldc_line_driver_ctrl_sva

bind ldc_line_driver_ctrl ldc_line_driver_ctrl_sva sva (.CLK_I, .SRST_I, .REG_ADDR_I,
   .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .REGISTER_CORRUPTION_FLAG_I,
   .LIMIT_LEVEL_O, .LIMIT_ACTIVE_O, .LOW_RAIL_REG_ON_O, .WAKE_DETECT_EN_O,
   .LINE_SLEW_SELECT_O, .LINE_WEAK_PULLDOWN_O, .LINE_WEAK_PULLUP_O, .LINE_HIGH_SIDE_ON_O,
   .LINE_LOW_SIDE_ON_O, .LINE_FAULT_O, .AUX_DRV_ACTIVE_O, .AUX_DRV_LEVEL_O, .RX_OE_O,
   .AUX_LOGIC_PIN_O, .AUX_LOGIC_PIN_OE_O, .LINE_LEVEL_STATUS_O, .AUX_LEVEL_STATUS_O);

// ===== testbench/test_line_driver_control_regs.sv
module test_line_driver_control_regs;
   timeunit 1ns;
   timeprecision 1ns;
   logic       CLK_I, SRST_I, REG_WR_I, REG_RD_I, TX_I, TXEN_I, LINE_SENSE_I, AUX_SENSE_I;
   logic       LINE_OVERCUR_I, AUX_OVERCUR_I, AUX_DRV_EN_I, REGISTER_CORRUPTION_FLAG_I;
   logic [7:0] REG_ADDR_I, REG_WDATA_I, REG_RDATA_O;
   logic [1:0] LIMIT_LEVEL_O, LINE_SLEW_SELECT_O;
   logic       LIMIT_ACTIVE_O, LOW_RAIL_REG_ON_O, WAKE_DETECT_EN_O, LINE_WEAK_PULLDOWN_O;
   logic       LINE_WEAK_PULLUP_O, LINE_HIGH_SIDE_ON_O, LINE_LOW_SIDE_ON_O, LINE_FAULT_O;
   logic       AUX_DRV_ACTIVE_O, AUX_DRV_LEVEL_O, AUX_FAULT_O, RX_O, RX_OE_O, AUX_LOGIC_PIN_O;
   logic       AUX_LOGIC_PIN_OE_O, LINE_LEVEL_STATUS_O, AUX_LEVEL_STATUS_O;
   int         bad_count, samples_checked, n;
   logic [7:0] v, c, t, l;
   int         blank_cyc[4] = '{1280, 20, 30, 40};
   int         retry_cyc[4] = '{50, 60, 70, 80};

   // Long counts shortened; blanking code 00 keeps its fixed count
   ldc_line_driver_ctrl #(.BLANK_500US_CYC(20), .BLANK_1MS_CYC(30), .BLANK_5MS_CYC(40),
      .RETRY_50MS_CYC(50), .RETRY_100MS_CYC(60), .RETRY_200MS_CYC(70),
      .RETRY_500MS_CYC(80)) dut (.CLK_I, .SRST_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I,
      .REG_RD_I, .REG_RDATA_O, .TX_I, .TXEN_I, .LINE_SENSE_I, .AUX_SENSE_I, .LINE_OVERCUR_I,
      .AUX_OVERCUR_I, .AUX_DRV_EN_I, .REGISTER_CORRUPTION_FLAG_I, .LIMIT_LEVEL_O,
      .LIMIT_ACTIVE_O, .LOW_RAIL_REG_ON_O, .WAKE_DETECT_EN_O, .LINE_SLEW_SELECT_O,
      .LINE_WEAK_PULLDOWN_O, .LINE_WEAK_PULLUP_O, .LINE_HIGH_SIDE_ON_O, .LINE_LOW_SIDE_ON_O,
      .LINE_FAULT_O, .AUX_DRV_ACTIVE_O, .AUX_DRV_LEVEL_O, .AUX_FAULT_O, .RX_O, .RX_OE_O,
      .AUX_LOGIC_PIN_O, .AUX_LOGIC_PIN_OE_O, .LINE_LEVEL_STATUS_O, .AUX_LEVEL_STATUS_O);
   ldc_host_model host (.clk_i(CLK_I), .rdata_i(REG_RDATA_O), .addr_o(REG_ADDR_I),
      .wdata_o(REG_WDATA_I), .wr_o(REG_WR_I), .rd_o(REG_RD_I));

   // Expected {high side, low side} from enable, mode, polarity and line data
   function automatic logic [1:0] drv_exp(logic [3:0] f, logic d);
      logic p;
      p = f[1] ? d : ~d;
      if (!f[0]) return 2'b00;
      if (f[2]) return {p, ~p};
      return f[3] ? {1'b0, ~p} : {p, 1'b0};
   endfunction

   task automatic chk_reg(logic [7:0] e, logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_pin(logic [1:0] e, logic [1:0] g);
      chk_reg({6'h00, e}, {6'h00, g});
   endtask
   task automatic tick(int k);
      repeat (k) @(posedge CLK_I);
      #1;
   endtask
   task automatic test_done();
      if (bad_count == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      CLK_I = 1'b0;
      forever #50 CLK_I = ~CLK_I;
   end
   // Whole run is a few thousand cycles; this cuts a hang short
   initial begin
      repeat (20000) @(posedge CLK_I);
      bad_count++;
      test_done();
   end

   initial begin
      {SRST_I, TXEN_I, LINE_SENSE_I, AUX_SENSE_I} = 4'hF;
      {TX_I, LINE_OVERCUR_I, AUX_OVERCUR_I, AUX_DRV_EN_I, REGISTER_CORRUPTION_FLAG_I} = 5'h00;
      void'($urandom(32'h3D962956));
      repeat (12) @(posedge CLK_I);
      #1 SRST_I = 1'b0;
      // Reset values, unmapped place ignored on write and zero on read
      host.wr(8'h10, 8'hFF);
      for (int a = 4; a < 8; a++) begin
         host.rd(8'(a), v);
         chk_reg(8'h00, v);
      end
      // Random contents read back and reflected on the control outputs
      repeat (8) begin
         c = $urandom;
         t = $urandom;
         l = $urandom;
         AUX_DRV_EN_I = 1'($urandom);
         host.wr(8'h05, c);
         host.wr(8'h06, t);
         host.wr(8'h07, l);
         host.rd(8'h05, v);
         chk_reg(c, v);
         host.rd(8'h06, v);
         chk_reg(t, v);
         host.rd(8'h07, v);
         chk_reg(l, v);
         chk_reg({c[7:6], ~c[5], ~t[7], ~t[6], l[7:5]}, {LIMIT_LEVEL_O, LIMIT_ACTIVE_O,
            LOW_RAIL_REG_ON_O, WAKE_DETECT_EN_O, LINE_SLEW_SELECT_O, LINE_WEAK_PULLDOWN_O});
         chk_pin({l[4], t[1]}, {LINE_WEAK_PULLUP_O, AUX_DRV_LEVEL_O});
         chk_pin({AUX_DRV_EN_I, ~AUX_DRV_EN_I}, {AUX_DRV_ACTIVE_O, AUX_LOGIC_PIN_OE_O});
      end
      // Every mode, polarity, enable, transmit and soft level combination
      for (int i = 0; i < 64; i++) begin
         v = 8'(i);
         TX_I = v[5];
         TXEN_I = 1'($urandom);
         host.wr(8'h06, {7'h00, v[4]});
         host.wr(8'h07, {4'h0, v[3:0]});
         tick(2);
         chk_pin(drv_exp({v[3:1], v[0] & TXEN_I}, v[5] | v[4]),
            {LINE_HIGH_SIDE_ON_O, LINE_LOW_SIDE_ON_O});
      end
      TXEN_I = 1'b0;
      tick(2);
      chk_pin(2'b00, {LINE_HIGH_SIDE_ON_O, LINE_LOW_SIDE_ON_O});
      TXEN_I = 1'b1;
      // Receive polarity with the line high
      for (int k = 0; k < 2; k++) begin
         host.wr(8'h07, {6'h00, k[0], 1'b0});
         tick(4);
         chk_pin({1'b0, k[0]}, {1'b0, RX_O});
      end
      // Glitch filters: a held low is still blocked after 8 cycles and has passed by 14
      for (int k = 0; k < 2; k++) begin
         host.wr(8'h06, k ? 8'h10 : 8'h04);
         {AUX_SENSE_I, LINE_SENSE_I} = k ? 2'b01 : 2'b10;
         tick(8);
         chk_pin(2'b00, {AUX_LEVEL_STATUS_O, LINE_LEVEL_STATUS_O});
         tick(6);
         chk_pin(k ? 2'b10 : 2'b01, {AUX_LEVEL_STATUS_O, LINE_LEVEL_STATUS_O});
         {AUX_SENSE_I, LINE_SENSE_I} = 2'b11;
         tick(14);
      end
      // Receiver disables clear status and float the receive output
      {AUX_SENSE_I, LINE_SENSE_I} = 2'b00;
      host.wr(8'h06, 8'h00);
      tick(4);
      chk_pin(2'b11, {AUX_LEVEL_STATUS_O, LINE_LEVEL_STATUS_O});
      host.wr(8'h06, 8'h28);
      tick(2);
      chk_pin(2'b00, {AUX_LEVEL_STATUS_O, LINE_LEVEL_STATUS_O});
      chk_pin(2'b00, {RX_OE_O, AUX_LOGIC_PIN_O});
      // Auto retry: blanking then timed off per code, driver back on its own
      host.wr(8'h06, 8'h00);
      host.wr(8'h07, 8'h05);
      AUX_DRV_EN_I = 1'b1;
      for (int b = 0; b < 4; b++) begin
         host.wr(8'h05, {3'b000, b[1:0], b[1:0], 1'b1});
         tick(2);
         LINE_OVERCUR_I = 1'b1;
         for (n = 0; LINE_FAULT_O !== 1'b1 && n < 2000; n++) tick(1);
         chk_pin(2'b11, {n >= blank_cyc[b], n <= blank_cyc[b] + 3});
         LINE_OVERCUR_I = 1'b0;
         for (n = 0; LINE_FAULT_O !== 1'b0 && n < 2000; n++) tick(1);
         chk_pin(2'b11, {n >= retry_cyc[b] - 3, n <= retry_cyc[b] + 3});
         tick(2);
         chk_pin(drv_exp(4'h5, TX_I), {LINE_HIGH_SIDE_ON_O, LINE_LOW_SIDE_ON_O});
      end
      // Auto retry off: both faults latch until the limit register is written
      host.wr(8'h05, 8'h08);
      {AUX_OVERCUR_I, LINE_OVERCUR_I} = 2'b11;
      tick(40);
      {AUX_OVERCUR_I, LINE_OVERCUR_I} = 2'b00;
      tick(200);
      chk_pin(2'b11, {AUX_FAULT_O, LINE_FAULT_O});
      chk_pin(2'b00, {LINE_HIGH_SIDE_ON_O, LINE_LOW_SIDE_ON_O});
      host.wr(8'h05, 8'h08);
      tick(3);
      chk_pin(2'b00, {AUX_FAULT_O, LINE_FAULT_O});
      // Corruption shuts drivers, floats outputs and forces the low rail on
      AUX_DRV_EN_I = 1'b0;
      host.wr(8'h06, 8'h80);
      REGISTER_CORRUPTION_FLAG_I = 1'b1;
      tick(2);
      chk_pin(2'b00, {LINE_HIGH_SIDE_ON_O, LINE_LOW_SIDE_ON_O});
      chk_pin(2'b00, {RX_OE_O, AUX_LOGIC_PIN_OE_O});
      chk_pin(2'b10, {LOW_RAIL_REG_ON_O, AUX_DRV_ACTIVE_O});
      REGISTER_CORRUPTION_FLAG_I = 1'b0;
      tick(2);
      chk_pin(2'b01, {LOW_RAIL_REG_ON_O, RX_OE_O});
      test_done();
   end
endmodule // test_line_driver_control_regs
